// ---- dcsrm_regs.vh ----
// register map constants for the dual channel serial register bank
`ifndef DCSRM_REGS_VH
`define DCSRM_REGS_VH
`define DCSRM_ADDR_W        13
`define DCSRM_A_PORT_CFG    13'h0000
`define DCSRM_A_DEV_ID      13'h0001
`define DCSRM_A_GRADE       13'h0002
`define DCSRM_A_CH_SEL      13'h0005
`define DCSRM_A_XFER        13'h00FF
`define DCSRM_A_SHD_LO      13'h0008
`define DCSRM_A_SHD_HI      13'h0038
`define DCSRM_A_PROG_HI     13'h0025
`define DCSRM_A_MODES       13'h0008
`define DCSRM_A_CLOCK       13'h0009
`define DCSRM_A_GAP         13'h0013
`define DCSRM_RST_PORT_CFG  8'h18
`define DCSRM_RST_CH_SEL    8'h03
`define DCSRM_RST_MODES     8'h00
`define DCSRM_RST_CLOCK     8'h01
`define DCSRM_RST_XFER      8'h00
`define DCSRM_RST_GRADE     8'h00
`define DCSRM_XFER_CMD      8'h01
`define DCSRM_CFG_LSB_HI    6
`define DCSRM_CFG_LSB_LO    1
`define DCSRM_CFG_SRST_HI   5
`define DCSRM_CFG_SRST_LO   2
`define DCSRM_CFG_ONES      8'h18
`define DCSRM_CFG_MASK      8'h66
`define DCSRM_CH_A_BIT      0
`define DCSRM_CH_B_BIT      1
`define DCSRM_MODES_MASK    8'h03
`define DCSRM_CLOCK_MASK    8'h01
`define DCSRM_CH_SEL_MASK   8'h03
`define DCSRM_INSTR_BITS    5'd16
`define DCSRM_RW_BIT        15
`define DCSRM_LEN_HI        14
`define DCSRM_LEN_LO        13
`define DCSRM_SHD_DEPTH     64
`endif

// ---- dcsrm_shadow_mem.v ----
// holding and operating copies of the program registers, one bank per channel
`timescale 1ns/10ps
module dcsrm_shadow_mem #(
  parameter DEPTH = 64,
  parameter AW    = 6
) (
  // clock and reset
  input  wire          ref_clk,
  input  wire          sys_rst,
  // holding side write and read
  input  wire          hold_we,
  input  wire [AW-1:0] hold_addr,
  input  wire [7:0]    hold_wdata,
  output reg  [7:0]    hold_rdata_ff,
  // commit all holding words at once
  input  wire          commit,
  // operating copy readout
  input  wire [AW-1:0] oper_addr,
  output reg  [7:0]    oper_rdata_ff
);
  reg [7:0] hold_ff [0:DEPTH-1];
  reg [7:0] oper_ff [0:DEPTH-1];
  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1) begin : g_word
      localparam [AW-1:0] WORD_IDX = i;
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          hold_ff[i] <= 8'h00;
          oper_ff[i] <= 8'h00;
        end else begin
          if (hold_we && hold_addr == WORD_IDX)
            hold_ff[i] <= hold_wdata;
          // all words copy in one edge so settings move together
          if (commit)
            oper_ff[i] <= hold_ff[i];
        end
      end
    end
  endgenerate
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      hold_rdata_ff <= 8'h00;
      oper_rdata_ff <= 8'h00;
    end else begin
      hold_rdata_ff <= hold_ff[hold_addr];
      oper_rdata_ff <= oper_ff[oper_addr];
    end
  end
endmodule // dcsrm_shadow_mem

// ---- dcsrm_spi_regs.v ----
// serial port slave and register bank for the dual channel converter
`timescale 1ns/10ps
`include "dcsrm_regs.vh"
module dcsrm_spi_regs #(
  parameter [7:0] DEV_ID    = 8'h5C, // arbitrary identification value
  parameter       SHD_DEPTH = `DCSRM_SHD_DEPTH
) (
  // clock and reset
  input  wire       ref_clk,
  input  wire       sys_rst,
  // serial pins, sampled on ref_clk
  input  wire       sclk_pin,
  input  wire       select_n_pin,
  input  wire       serial_data_powerdown_pin_i,
  output reg        serial_data_powerdown_pin_o_ff,
  output reg        serial_data_powerdown_pin_oe_n_ff,
  // operating settings for the converter
  output reg        powerdown_ff,
  output reg  [1:0] pd_mode_a_ff,
  output reg  [1:0] pd_mode_b_ff,
  output reg        duty_cycle_stabilizer_ff,
  output reg        port_active_ff
);
  localparam AW = 6;
  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_INSTR = 3'd1;
  localparam [2:0] ST_WDATA = 3'd2;
  localparam [2:0] ST_RLOAD = 3'd3;
  localparam [2:0] ST_RDATA = 3'd4;

  // pin synchronisers
  reg [1:0] sclk_sync_ff;
  reg [1:0] sel_sync_ff;
  reg [1:0] sdi_sync_ff;
  reg       sclk_d_ff;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sclk_sync_ff <= 2'b00;
      sel_sync_ff  <= 2'b11;
      sdi_sync_ff  <= 2'b11;
      sclk_d_ff    <= 1'b0;
    end else begin
      sclk_sync_ff <= {sclk_sync_ff[0], sclk_pin};
      sel_sync_ff  <= {sel_sync_ff[0], select_n_pin};
      sdi_sync_ff  <= {sdi_sync_ff[0], serial_data_powerdown_pin_i};
      sclk_d_ff    <= sclk_sync_ff[1];
    end
  end
  wire sclk_s  = sclk_sync_ff[1];
  wire sel_n_s = sel_sync_ff[1];
  wire sdi_s   = sdi_sync_ff[1];
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;

  // registers
  reg [7:0]  port_cfg_ff;
  reg [7:0]  ch_sel_ff;
  reg [7:0]  xfer_ff;
  reg [7:0]  modes_hold_ff;
  reg [7:0]  modes_oper_ff;
  reg [7:0]  clock_hold_ff;
  reg [7:0]  clock_oper_ff;
  reg        port_used_ff;
  // serial engine
  reg [2:0]  state_ff;
  reg [15:0] sh_ff;
  reg [4:0]  cnt_ff;
  reg [12:0] addr_ff;
  reg        rd_ff;
  reg [7:0]  rbyte_ff;

  wire lsb_first = port_cfg_ff[`DCSRM_CFG_LSB_HI] | port_cfg_ff[`DCSRM_CFG_LSB_LO];
  wire soft_rst  = port_cfg_ff[`DCSRM_CFG_SRST_HI] | port_cfg_ff[`DCSRM_CFG_SRST_LO];
  wire sel_a = ch_sel_ff[`DCSRM_CH_A_BIT];
  wire sel_b = ch_sel_ff[`DCSRM_CH_B_BIT];

  // incoming byte assembled in the current bit order
  wire [7:0] in_byte = lsb_first ? {sdi_s, sh_ff[7:1]} : {sh_ff[6:0], sdi_s};
  wire       byte_done = sclk_rise && cnt_ff == 5'd7;
  wire       wr_strobe = (state_ff == ST_WDATA) && byte_done;

  wire in_shadow = addr_ff >= `DCSRM_A_SHD_LO && addr_ff <= `DCSRM_A_SHD_HI;
  wire [12:0]   shd_off  = addr_ff - `DCSRM_A_SHD_LO;
  wire [AW-1:0] mem_addr = shd_off[AW-1:0];
  wire is_local = in_shadow && addr_ff != `DCSRM_A_MODES && addr_ff != `DCSRM_A_CLOCK;
  wire mem_we_a = wr_strobe && is_local && sel_a;
  wire mem_we_b = wr_strobe && is_local && sel_b;
  wire xfer_go  = xfer_ff[0];
  wire [7:0] mem_rd_a;
  wire [7:0] mem_rd_b;

  dcsrm_shadow_mem #(.DEPTH(SHD_DEPTH), .AW(AW)) u_mem_a (
    .ref_clk(ref_clk), .sys_rst(sys_rst | soft_rst), .hold_we(mem_we_a), .hold_addr(mem_addr),
    .hold_wdata(in_byte), .hold_rdata_ff(mem_rd_a), .commit(xfer_go), .oper_addr(mem_addr),
    .oper_rdata_ff());
  dcsrm_shadow_mem #(.DEPTH(SHD_DEPTH), .AW(AW)) u_mem_b (
    .ref_clk(ref_clk), .sys_rst(sys_rst | soft_rst), .hold_we(mem_we_b), .hold_addr(mem_addr),
    .hold_wdata(in_byte), .hold_rdata_ff(mem_rd_b), .commit(xfer_go), .oper_addr(mem_addr),
    .oper_rdata_ff());

  // read mux
  reg [7:0] rd_mux;
  always @* begin
    rd_mux = 8'h00;
    if (addr_ff == `DCSRM_A_PORT_CFG) begin
      rd_mux = port_cfg_ff | `DCSRM_CFG_ONES;
    end else if (addr_ff == `DCSRM_A_DEV_ID) begin
      rd_mux = DEV_ID;
    end else if (addr_ff == `DCSRM_A_GRADE) begin
      rd_mux = `DCSRM_RST_GRADE;
    end else if (addr_ff == `DCSRM_A_CH_SEL) begin
      rd_mux = ch_sel_ff;
    end else if (addr_ff == `DCSRM_A_XFER) begin
      rd_mux = xfer_ff;
    end else if (addr_ff == `DCSRM_A_MODES) begin
      rd_mux = modes_hold_ff;
    end else if (addr_ff == `DCSRM_A_CLOCK) begin
      rd_mux = clock_hold_ff;
    end else if (is_local) begin
      rd_mux = sel_a ? mem_rd_a : mem_rd_b;
    end
  end

  // serial state machine
  always @(posedge ref_clk) begin
    if (sys_rst || sel_n_s) begin
      // select high ends any frame; high at all times keeps port off
      state_ff <= ST_IDLE;
      cnt_ff   <= 5'd0;
      sh_ff    <= 16'h0000;
      addr_ff  <= 13'h0000;
      rd_ff    <= 1'b0;
      rbyte_ff <= 8'h00;
      serial_data_powerdown_pin_oe_n_ff <= 1'b1;
      serial_data_powerdown_pin_o_ff    <= 1'b0;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_INSTR;
          cnt_ff   <= 5'd0;
        end
        ST_INSTR: begin
          if (sclk_rise) begin
            sh_ff  <= lsb_first ? {sdi_s, sh_ff[15:1]} : {sh_ff[14:0], sdi_s};
            cnt_ff <= cnt_ff + 5'd1;
            if (cnt_ff == `DCSRM_INSTR_BITS - 5'd1) begin
              if (lsb_first) begin
                rd_ff   <= sdi_s;
                addr_ff <= sh_ff[13:1];
              end else begin
                rd_ff   <= sh_ff[14];
                addr_ff <= {sh_ff[11:0], sdi_s};
              end
              cnt_ff   <= 5'd0;
              state_ff <= (lsb_first ? sdi_s : sh_ff[14]) ? ST_RLOAD : ST_WDATA;
            end
          end
        end
        ST_WDATA: begin
          if (sclk_rise) begin
            sh_ff  <= {8'h00, in_byte};
            cnt_ff <= (cnt_ff == 5'd7) ? 5'd0 : cnt_ff + 5'd1;
          end
          if (byte_done)
            addr_ff <= lsb_first ? addr_ff + 13'd1 : addr_ff - 13'd1; // streaming
        end
        ST_RLOAD: begin
          // memory read data is registered: wait one extra edge after a new address
          if (cnt_ff == 5'd0) begin
            cnt_ff <= 5'd2;
          end else if (sclk_fall || cnt_ff == 5'd2) begin
            rbyte_ff <= rd_mux;
            state_ff <= ST_RDATA;
            cnt_ff   <= 5'd0;
          end
        end
        ST_RDATA: begin
          serial_data_powerdown_pin_oe_n_ff <= 1'b0;
          if (sclk_fall) begin
            serial_data_powerdown_pin_o_ff <= lsb_first ? rbyte_ff[cnt_ff[2:0]] : rbyte_ff[3'd7 - cnt_ff[2:0]];
            cnt_ff <= cnt_ff + 5'd1;
            if (cnt_ff == 5'd7) begin
              addr_ff  <= lsb_first ? addr_ff + 13'd1 : addr_ff - 13'd1;
              state_ff <= ST_RLOAD;
              cnt_ff   <= 5'd1;
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // register writes; gaps such as 0x04 simply drop writes, while 0x13 is a shadow memory word and takes writes
  always @(posedge ref_clk) begin
    if (sys_rst || soft_rst) begin
      port_cfg_ff   <= `DCSRM_RST_PORT_CFG;
      ch_sel_ff     <= `DCSRM_RST_CH_SEL;
      xfer_ff       <= `DCSRM_RST_XFER;
      modes_hold_ff <= `DCSRM_RST_MODES;
      modes_oper_ff <= `DCSRM_RST_MODES;
      clock_hold_ff <= `DCSRM_RST_CLOCK;
      clock_oper_ff <= `DCSRM_RST_CLOCK;
    end else begin
      if (xfer_go) begin
        modes_oper_ff <= modes_hold_ff;
        clock_oper_ff <= clock_hold_ff;
      end
      // a command arriving as the bit clears still lands
      xfer_ff <= (wr_strobe && addr_ff == `DCSRM_A_XFER) ? (in_byte & `DCSRM_XFER_CMD) : 8'h00;
      if (wr_strobe) begin
        if (addr_ff == `DCSRM_A_PORT_CFG)
          port_cfg_ff <= (in_byte & `DCSRM_CFG_MASK) | `DCSRM_CFG_ONES;
        else if (addr_ff == `DCSRM_A_CH_SEL)
          ch_sel_ff <= in_byte & `DCSRM_CH_SEL_MASK;
        else if (addr_ff == `DCSRM_A_MODES)
          modes_hold_ff <= in_byte & `DCSRM_MODES_MASK;
        else if (addr_ff == `DCSRM_A_CLOCK)
          clock_hold_ff <= in_byte & `DCSRM_CLOCK_MASK;
      end
    end
  end

  // pin strap fallback and outputs
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      port_used_ff             <= 1'b0;
      port_active_ff           <= 1'b0;
      powerdown_ff             <= 1'b1;
      pd_mode_a_ff             <= 2'b00;
      pd_mode_b_ff             <= 2'b00;
      duty_cycle_stabilizer_ff <= 1'b1;
    end else begin
      if (!sel_n_s)
        port_used_ff <= 1'b1;
      port_active_ff <= port_used_ff;
      // until the port is ever selected the data pin is a static control
      powerdown_ff <= port_used_ff ? (modes_oper_ff[1:0] == 2'b01) : sdi_s;
      pd_mode_a_ff <= modes_oper_ff[1:0];
      pd_mode_b_ff <= modes_oper_ff[1:0];
      duty_cycle_stabilizer_ff <= clock_oper_ff[0];
    end
  end
endmodule // dcsrm_spi_regs

// ---- dcsrm_spi_regs_properties.sv ----
// port assertions for the serial register bank
`timescale 1ns/10ps
module dcsrm_spi_regs_properties (
  // clock and reset
  input wire       ref_clk,
  input wire       sys_rst,
  // serial pins
  input wire       select_n_pin,
  input wire       serial_data_powerdown_pin_i,
  input wire       serial_data_powerdown_pin_oe_n_ff,
  // operating settings
  input wire       powerdown_ff,
  input wire [1:0] pd_mode_a_ff,
  input wire [1:0] pd_mode_b_ff,
  input wire       duty_cycle_stabilizer_ff,
  input wire       port_active_ff
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  a_reset_values:
    assert property (disable iff (1'b0) sys_rst |=> serial_data_powerdown_pin_oe_n_ff && powerdown_ff
      && duty_cycle_stabilizer_ff && pd_mode_a_ff == 2'b00 && !port_active_ff) else $error("reset values wrong");
  a_idle_no_drive:
    assert property (select_n_pin[*5] |-> serial_data_powerdown_pin_oe_n_ff) else $error("pin driven while idle");
  a_strap_follow:
    assert property ((!port_active_ff && $stable(serial_data_powerdown_pin_i))[*5]
      |-> powerdown_ff == serial_data_powerdown_pin_i) else $error("powerdown not following pin");
  a_port_sticky:
    assert property (port_active_ff && !select_n_pin |=> port_active_ff) else $error("port activity lost");
  a_port_wakes:
    assert property ((!select_n_pin)[*3] |-> ##[0:3] port_active_ff) else $error("port not activated");
  a_pd_from_modes:
    assert property ((port_active_ff && $stable(pd_mode_a_ff))[*3] |-> powerdown_ff == (pd_mode_a_ff == 2'b01))
      else $error("powerdown not from modes");
  a_ops_quiet:
    assert property (select_n_pin[*8] |-> $stable(pd_mode_a_ff) && $stable(duty_cycle_stabilizer_ff))
      else $error("operating setting moved");
  a_modes_global:
    assert property (pd_mode_a_ff == pd_mode_b_ff) else $error("channel modes differ");
  c_read_drive: cover property ($fell(serial_data_powerdown_pin_oe_n_ff));
  c_full_pd: cover property (port_active_ff && pd_mode_a_ff == 2'b01);
  c_dcs_off: cover property ($fell(duty_cycle_stabilizer_ff));
endmodule // dcsrm_spi_regs_properties
bind dcsrm_spi_regs dcsrm_spi_regs_properties u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .select_n_pin(select_n_pin), .serial_data_powerdown_pin_i(serial_data_powerdown_pin_i),
  .serial_data_powerdown_pin_oe_n_ff(serial_data_powerdown_pin_oe_n_ff), .powerdown_ff(powerdown_ff),
  .pd_mode_a_ff(pd_mode_a_ff), .pd_mode_b_ff(pd_mode_b_ff),
  .duty_cycle_stabilizer_ff(duty_cycle_stabilizer_ff), .port_active_ff(port_active_ff));

// ---- dcsrm_host.sv ----
// serial host model for the configuration port
`timescale 1ns/10ps
module dcsrm_host #(
  parameter HALF = 8
) (
  // clock
  input  wire ref_clk,
  // serial pins
  output reg  sclk,
  output reg  sel_n,
  output reg  mosi,
  input  wire line
);
  integer i;
  initial begin
    sclk = 1'b0;
    sel_n = 1'b1;
    mosi = 1'b1;
  end
  // pin as plain powerdown input until the port is first selected
  task strap(input v);
    mosi <= v;
  endtask
  // msb first: rw, length 00, address, one byte
  task xfer(input rw, input [12:0] a, input [7:0] wd, output [7:0] rdat);
    reg [23:0] f;
    begin
      f = {rw, 2'b00, a, wd};
      sel_n <= 1'b0;
      repeat (HALF) @(posedge ref_clk);
      for (i = 23; i >= 0; i = i - 1) begin
        sclk <= 1'b0;
        // released line toggles so a missed drive never reads as data
        mosi <= (rw && i < 8) ? ~mosi : f[i];
        repeat (HALF) @(posedge ref_clk);
        rdat[i % 8] = line;
        sclk <= 1'b1;
        repeat (HALF) @(posedge ref_clk);
      end
      sel_n <= 1'b1;
      mosi <= ~mosi;
      repeat (4 * HALF) @(posedge ref_clk);
    end
  endtask
endmodule // dcsrm_host

// ---- dual_channel_spi_register_map_test.sv ----
// self-checking bench for the serial register bank
`timescale 1ns/10ps
module dual_channel_spi_register_map_test;
  localparam [7:0] ID_VAL = 8'h3B; // arbitrary identification value
  reg        ref_clk;
  reg        sys_rst;
  wire       sclk, sel_n, mosi, dev_o, dev_oe_n, pd, duty_cycle_stabilizer, act;
  wire [1:0] pda, pdb;
  wire       line = dev_oe_n ? mosi : dev_o;
  integer    err_total, n_tests, seed, i;
  reg  [7:0] r, va, vb, vc, d;
  reg  [1:0] pm;
  reg        pc;
  always #50 ref_clk = ~ref_clk;
  dcsrm_spi_regs #(.DEV_ID(ID_VAL)) u_dcsrm_spi_regs (.ref_clk(ref_clk), .sys_rst(sys_rst), .sclk_pin(sclk),
    .select_n_pin(sel_n), .serial_data_powerdown_pin_i(line), .serial_data_powerdown_pin_o_ff(dev_o),
    .serial_data_powerdown_pin_oe_n_ff(dev_oe_n), .powerdown_ff(pd), .pd_mode_a_ff(pda), .pd_mode_b_ff(pdb),
    .duty_cycle_stabilizer_ff(duty_cycle_stabilizer), .port_active_ff(act));
  dcsrm_host u_dcsrm_host (.ref_clk(ref_clk), .sclk(sclk), .sel_n(sel_n), .mosi(mosi), .line(line));
  function [7:0] ops(input [1:0] m, input c);
    ops = {2'b00, m == 2'b01, m, m, c};
  endfunction
  task check(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  task wr(input [12:0] a, input [7:0] v);
    u_dcsrm_host.xfer(1'b0, a, v, r);
  endtask
  task rd(input [12:0] a, input [7:0] exp);
    begin
      u_dcsrm_host.xfer(1'b1, a, 8'h00, r);
      check("read", exp, r);
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total = err_total + 1;
    tally_and_finish;
  end
  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    err_total = 0;
    n_tests = 0;
    seed = 32'h1d11c9cd;
    va = $random(seed) & 8'h37;
    vb = $random(seed) & 8'h37;
    vc = $random(seed) & 8'h37;
    pm = 2'b00;
    pc = 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    check("reset", 8'h42, {1'b0, pd, pda, pdb, duty_cycle_stabilizer, act});
    u_dcsrm_host.strap(1'b0);
    repeat (6) @(posedge ref_clk);
    check("strap", 8'h00, {7'h00, pd});
    u_dcsrm_host.strap(1'b1);
    repeat (6) @(posedge ref_clk);
    check("strap", 8'h01, {7'h00, pd});
    rd(13'h0000, 8'h18);
    wr(13'h0001, 8'hA5);
    rd(13'h0001, ID_VAL);
    rd(13'h0005, 8'h03);
    rd(13'h0013, 8'h00);
    for (i = 0; i < 2; i = i + 1) begin
      d = $random(seed) & 8'h01;
      wr(13'h0008, i[7:0]);
      wr(13'h0009, d);
      check("held", ops(pm, pc), {2'b00, pd, pda, pdb, duty_cycle_stabilizer});
      wr(13'h00FF, 8'h01);
      check("commit", ops(i[1:0], d[0]), {2'b00, pd, pda, pdb, duty_cycle_stabilizer});
      rd(13'h00FF, 8'h00);
      pm = i[1:0];
      pc = d[0];
    end
    wr(13'h0005, 8'h01);
    wr(13'h000D, va);
    wr(13'h0005, 8'h02);
    wr(13'h000D, vb);
    wr(13'h0008, 8'h00);
    wr(13'h00FF, 8'h01);
    check("global", ops(2'b00, pc), {2'b00, pd, pda, pdb, duty_cycle_stabilizer});
    wr(13'h0005, 8'h01);
    rd(13'h000D, va);
    rd(13'h0008, 8'h00);
    wr(13'h0005, 8'h02);
    rd(13'h000D, vb);
    wr(13'h0005, 8'h03);
    rd(13'h000D, va);
    wr(13'h000D, vc);
    wr(13'h00FF, 8'h01);
    wr(13'h0005, 8'h02);
    rd(13'h000D, vc);
    wr(13'h0000, 8'h24);
    check("soft rst", 8'h01, {3'b000, pda, pdb, duty_cycle_stabilizer});
    rd(13'h0000, 8'h18);
    rd(13'h0005, 8'h03);
    tally_and_finish;
  end
endmodule // dual_channel_spi_register_map_test
